// File: rtl/sram_port_pkg.sv
// Shared constants and types of the synchronous burst memory port
package sram_port_pkg;

	// ********************************************************
	// Geometry
	// ********************************************************
	localparam int ADDR_W = 19;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int MEM_WORDS = 524288;
	localparam int BURST_W = 2;

	// ********************************************************
	// Reset values and encodings
	// ********************************************************
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic [LANES-1:0] MASK_NONE = 4'h0;
	localparam logic [LANES-1:0] MASK_ALL = 4'hf;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 19'h0_0000;

	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [1:0] {
		st_idle,
		st_burst,
		st_asleep
	} port_state_t;

	// Write qualifiers, all active low, sampled together
	typedef struct packed {
		logic all_bytes_write_n;
		logic byte_write_gate_n;
		logic [LANES-1:0] per_byte_write_n;
	} write_ctl_t;

	// Chip selects and burst controls sampled together
	typedef struct packed {
		logic select_low_a_n;
		logic select_high_b;
		logic select_low_c_n;
		logic cpu_address_strobe_n;
		logic cache_ctrl_address_strobe_n;
		logic burst_step_n;
	} access_ctl_t;

endpackage : sram_port_pkg

// File: rtl/sync_burst_sram_port.sv
// Synchronous flow-through burst memory port with its storage array
`timescale 1ns/1ns

module sync_burst_sram_port
	import sram_port_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Address, selects and burst control
	input wire logic [ADDR_W-1:0] addr,
	input wire access_ctl_t access_ctl,
	input wire logic burst_order,
	// Write qualifiers and write data
	input wire write_ctl_t write_ctl,
	input wire logic [DATA_W-1:0] data_in,
	// Output enable and sleep
	input wire logic output_enable_n,
	input wire logic sleep_request,
	// Read data pins
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	// Status
	output logic sleeping
);

	// ********************************************************
	// State
	// ********************************************************
	logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
	port_state_t state;
	port_state_t next_state;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] next_base;
	logic [BURST_W-1:0] burst_cnt;
	logic [BURST_W-1:0] next_burst_cnt;
	logic read_armed;
	logic next_read_armed;
	logic [DATA_W-1:0] next_data_out;
	logic next_data_oe;
	logic next_sleeping;

	// Decoded access for this cycle
	logic selected;
	logic any_strobe;
	logic cpu_start;
	logic ctrl_start;
	logic deselect;
	logic continue_burst;
	logic [LANES-1:0] req_mask;
	logic [LANES-1:0] wr_mask;
	logic do_read;
	logic [BURST_W-1:0] low_bits;
	logic [ADDR_W-1:0] acc_addr;
	logic [DATA_W-1:0] wr_word;

	// ********************************************************
	// Decode
	// ********************************************************
	// Chip select and strobes
	always_comb begin
		selected = !access_ctl.select_low_a_n && access_ctl.select_high_b &&
			!access_ctl.select_low_c_n;
		any_strobe = !access_ctl.cpu_address_strobe_n ||
			!access_ctl.cache_ctrl_address_strobe_n;
		cpu_start = !access_ctl.cpu_address_strobe_n && selected;
		ctrl_start = !access_ctl.cache_ctrl_address_strobe_n && selected &&
			access_ctl.cpu_address_strobe_n;
		deselect = any_strobe && !selected;
		continue_burst = !any_strobe && (state == st_burst);
	end

	// Byte lanes requested by the write qualifiers
	always_comb begin
		if (!write_ctl.all_bytes_write_n) begin
			req_mask = MASK_ALL;
		end else if (!write_ctl.byte_write_gate_n) begin
			req_mask = ~write_ctl.per_byte_write_n;
		end else begin
			req_mask = MASK_NONE;
		end
	end

	// ********************************************************
	// Access sequencing
	// ********************************************************
	// Next state, burst counter, address and pin control
	always_comb begin
		next_state = state;
		next_base = base;
		next_burst_cnt = burst_cnt;
		next_read_armed = read_armed;
		next_data_out = data_out;
		next_data_oe = 1'b0;
		next_sleeping = 1'b0;
		wr_mask = MASK_NONE;
		do_read = 1'b0;
		acc_addr = base;
		low_bits = base[BURST_W-1:0];
		if (sleep_request) begin
			// Controller has already deselected; nothing left to finish
			next_state = st_asleep;
			next_sleeping = 1'b1;
			next_read_armed = 1'b0;
		end else if (state == st_asleep) begin
			// Wake released; wait for a fresh strobed read to drive
			next_state = st_idle;
			next_read_armed = 1'b0;
		end else if (deselect) begin
			next_state = st_idle;
			next_read_armed = 1'b0;
		end else if (cpu_start || ctrl_start) begin
			next_state = st_burst;
			next_base = addr;
			next_burst_cnt = BURST_RST;
			acc_addr = addr;
			if (ctrl_start && req_mask != MASK_NONE) begin
				wr_mask = req_mask;
				next_read_armed = 1'b0;
			end else begin
				// Byte writes are not looked at on a cpu strobe
				do_read = 1'b1;
				next_read_armed = 1'b1;
			end
		end else if (continue_burst) begin
			if (!access_ctl.burst_step_n) begin
				next_burst_cnt = burst_cnt + BURST_STEP;
			end else begin
				next_burst_cnt = burst_cnt;
			end
			if (burst_order) begin
				low_bits = base[BURST_W-1:0] ^ next_burst_cnt;
			end else begin
				low_bits = base[BURST_W-1:0] + next_burst_cnt;
			end
			acc_addr = {base[ADDR_W-1:BURST_W], low_bits};
			if (req_mask != MASK_NONE) begin
				wr_mask = req_mask;
				next_read_armed = 1'b0;
			end else begin
				do_read = 1'b1;
			end
		end
		if (do_read) begin
			next_data_out = mem[acc_addr];
		end
		// A write cycle never drives, so a release always precedes a drive
		next_data_oe = do_read && next_read_armed && !output_enable_n;
	end

	// Registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= st_idle;
			base <= ADDR_RST;
			burst_cnt <= BURST_RST;
			read_armed <= 1'b0;
			data_out <= DATA_RST;
			data_oe <= 1'b0;
			sleeping <= 1'b0;
		end else begin
			state <= next_state;
			base <= next_base;
			burst_cnt <= next_burst_cnt;
			read_armed <= next_read_armed;
			data_out <= next_data_out;
			data_oe <= next_data_oe;
			sleeping <= next_sleeping;
		end
	end

	// ********************************************************
	// Storage
	// ********************************************************
	// Merge the enabled lanes with the word already stored
	generate
		for (genvar i = 0; i < LANES; i++) begin : g_lane
			assign wr_word[i*LANE_W +: LANE_W] = wr_mask[i] ?
				data_in[i*LANE_W +: LANE_W] :
				mem[acc_addr][i*LANE_W +: LANE_W];
		end
	endgenerate

	// Array has no reset; its contents are undefined until written
	always_ff @(posedge clock) begin
		if (rst_n && wr_mask != MASK_NONE) begin
			mem[acc_addr] <= wr_word;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	logic write_cycle;
	assign write_cycle = (wr_mask != MASK_NONE);

	// Strobe with a bad select combination never leads to driving
	property p_deselect_quiet;
		deselect && !sleep_request |=> !data_oe;
	endproperty
	a_deselect_quiet: assert property (p_deselect_quiet)
		else $error("Data driven after deselect");

	// Deselect then an unstrobed cycle stays released; a read may follow
	sequence s_deselect_then_quiet;
		deselect ##1 !any_strobe;
	endsequence
	property p_deselect_idle;
		s_deselect_then_quiet |=> !data_oe;
	endproperty
	a_deselect_idle: assert property (p_deselect_idle)
		else $error("Data driven while deselected");

	// Global write or gated all-lane write covers every lane
	property p_full_write;
		write_cycle && (!write_ctl.all_bytes_write_n ||
			(!write_ctl.byte_write_gate_n &&
			write_ctl.per_byte_write_n == MASK_NONE)) |->
			wr_mask == MASK_ALL;
	endproperty
	a_full_write: assert property (p_full_write)
		else $error("Full-width write lost lanes");

	// Write followed by an unstrobed cycle keeps the pins released
	sequence s_write_then_quiet;
		write_cycle ##1 !any_strobe;
	endsequence
	property p_hiz_after_write;
		s_write_then_quiet |=> !data_oe;
	endproperty
	a_hiz_after_write: assert property (p_hiz_after_write)
		else $error("Pins driven after write without new read");

	// Leaving sleep keeps the pins released for two cycles
	sequence s_wake;
		$fell(sleep_request);
	endsequence
	property p_wake_hiz;
		s_wake |-> !data_oe ##1 !data_oe;
	endproperty
	a_wake_hiz: assert property (p_wake_hiz)
		else $error("Pins driven on sleep exit");

	// Cpu strobe start never writes, whatever the byte inputs say
	property p_cpu_start_read;
		cpu_start && !sleep_request && state != st_asleep |->
			!write_cycle ##1 sleeping == 1'b0;
	endproperty
	a_cpu_start_read: assert property (p_cpu_start_read)
		else $error("Write taken on cpu strobe start");

	// Suspended burst keeps its counter
	property p_burst_hold;
		continue_burst && access_ctl.burst_step_n && !sleep_request |=>
			burst_cnt == $past(burst_cnt);
	endproperty
	a_burst_hold: assert property (p_burst_hold)
		else $error("Burst counter moved while suspended");

	// Pins drive only after a non-write read with output enable low
	property p_turnaround;
		data_oe |-> $past(do_read) && !$past(write_cycle) &&
			!$past(output_enable_n);
	endproperty
	a_turnaround: assert property (p_turnaround)
		else $error("Pins driven without release first");

	// Advancing burst steps by one and wraps in two bits
	property p_burst_step;
		continue_burst && !access_ctl.burst_step_n && !sleep_request |=>
			burst_cnt == $past(burst_cnt) + BURST_STEP;
	endproperty
	a_burst_step: assert property (p_burst_step)
		else $error("Burst counter did not advance by one");

	// Sleep request releases the pins and raises the status next cycle
	property p_sleep_quiet;
		sleep_request |=> !data_oe && sleeping;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("Pins driven or status low while asleep");

	// A strobed read with output enable low drives the pins again
	property p_read_drives;
		cpu_start && !sleep_request && state != st_asleep &&
			!output_enable_n |=> data_oe;
	endproperty
	a_read_drives: assert property (p_read_drives)
		else $error("Strobed read did not drive the pins");

endmodule : sync_burst_sram_port

// File: bench/host_bus_model.sv
// Bus controller model that drives the memory port
`timescale 1ns/1ns

// ****************
// Controller model
// ****************
module host_bus_model
	import sram_port_pkg::*;
#(
	parameter int POWER_UP_CYCLES = 125000
)
(
	// Clock
	input wire logic clock,
	// Bus towards the memory
	output access_ctl_t access_ctl,
	output write_ctl_t write_ctl,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] data_in,
	output logic sleep_request
);
	logic ready;

	// Idle bus, then the supply hold-off before any access
	initial begin
		access_ctl = access_ctl_t'(6'h33);
		write_ctl = write_ctl_t'(6'h3f);
		addr = ADDR_RST;
		data_in = DATA_RST;
		sleep_request = 1'b0;
		ready = 1'b0;
		repeat (POWER_UP_CYCLES) @(posedge clock);
		ready = 1'b1;
	end

	// One bus cycle; idle data lines flip so stale data never passes
	task automatic xfer(input logic [5:0] ac, input logic [5:0] wc,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic doze);
		@(posedge clock);
		while (!ready) @(posedge clock);
		sleep_request <= doze && (access_ctl == 6'h33);
		access_ctl <= access_ctl_t'(doze ? 6'h33 : ac);
		write_ctl <= write_ctl_t'(wc);
		addr <= a;
		data_in <= (wc[5:4] != 2'h3) ? d : ~data_in;
	endtask : xfer
endmodule : host_bus_model

// File: bench/tb_sync_burst_sram_port.sv
// Self-checking bench for the burst memory port
`timescale 1ns/1ns

// *****
// Bench
// *****
module tb_sync_burst_sram_port import sram_port_pkg::*;;
	typedef struct {
		int due;
		logic oe;
		logic slp;
		logic [DATA_W-1:0] d;
	} note_t;
	logic clock, rst_n, burst_order, output_enable_n, sleep_request;
	access_ctl_t access_ctl;
	write_ctl_t write_ctl;
	logic [ADDR_W-1:0] addr, base, cur, first;
	logic [DATA_W-1:0] data_in, data_out;
	logic data_oe, sleeping, armed, busy, oen, mode;
	logic [BURST_W-1:0] cnt;
	logic [LANES-1:0] ln;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	note_t q[$];
	int cyc, error_cnt, cmp_count, i;

	host_bus_model #(.POWER_UP_CYCLES(50)) i_host (.clock(clock),
		.access_ctl(access_ctl), .write_ctl(write_ctl), .addr(addr),
		.data_in(data_in), .sleep_request(sleep_request));
	sync_burst_sram_port i_dut (.clock(clock), .rst_n(rst_n),
		.addr(addr), .access_ctl(access_ctl), .burst_order(burst_order),
		.write_ctl(write_ctl), .data_in(data_in),
		.output_enable_n(output_enable_n), .sleep_request(sleep_request),
		.data_out(data_out), .data_oe(data_oe), .sleeping(sleeping));

	// Clock and cycle count
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;

	// One access and the outcome it should have one cycle later
	task automatic go(input logic [5:0] ac, input logic [5:0] wc,
		input logic [ADDR_W-1:0] a, input logic doze);
		logic [DATA_W-1:0] d;
		logic sel;
		note_t n;
		d = $urandom;
		sel = (ac[5:3] == 3'h2);
		i_host.xfer(ac, wc, a, d, doze);
		output_enable_n <= oen;
		burst_order <= mode;
		ln = !wc[5] ? MASK_ALL : (!wc[4] ? ~wc[3:0] : MASK_NONE);
		if (doze || (!sel && ac[2:1] != 2'h3) ||
			(ac[2:1] == 2'h3 && !busy)) begin
			busy = 1'b0;
			armed = 1'b0;
			ln = MASK_NONE;
		end else if (!ac[2] || !ac[1]) begin
			// A processor strobe start never writes
			if (!ac[2]) ln = MASK_NONE;
			first = a;
			cnt = BURST_RST;
			busy = 1'b1;
			armed = (ln == MASK_NONE);
		end else begin
			if (!ac[0]) cnt = cnt + BURST_STEP;
			if (ln != MASK_NONE) armed = 1'b0;
		end
		cur = {first[ADDR_W-1:2],
			mode ? first[1:0] ^ cnt : first[1:0] + cnt};
		for (int k = 0; k < LANES; k++) begin
			if (ln[k]) mem[cur][k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
		end
		n.oe = busy && armed && !oen && ln == MASK_NONE;
		n.slp = doze;
		n.due = cyc + 2;
		if (n.oe) n.d = mem[cur];
		q.push_back(n);
	endtask : go

	// Compare one outcome
	task automatic chk(input note_t n);
		cmp_count++;
		if (data_oe !== n.oe || sleeping !== n.slp ||
			(n.oe && data_out !== n.d)) begin
			error_cnt++;
			$display("[FAIL] %0t oe %b want %b data %h want %h", $time,
				data_oe, n.oe, data_out, n.d);
		end
	endtask : chk

	// Each note is judged in the cycle it falls due
	always @(negedge clock) begin
		while (q.size() > 0 && q[0].due <= cyc) begin
			chk(q.pop_front());
		end
	end

	// Counts and verdict
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	// Watchdog; the run needs about a hundred and ten cycles
	initial begin
		repeat (2000) @(posedge clock);
		error_cnt++;
		$display("[FAIL] %0t watchdog", $time);
		results();
	end

	// Main sequence
	initial begin
		{rst_n, burst_order, output_enable_n, oen, mode} = 5'h00;
		{busy, armed, cnt, cyc, error_cnt, cmp_count} = '0;
		void'($urandom(32'hb741));
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		base = ADDR_W'($urandom) & 19'h7fffc;
		for (i = 0; i < 4; i++) go(6'h15, i[0] ? 6'h1f : 6'h20, base + ADDR_W'(i), 0);
		go(6'h16, 6'h3f, base, 0);
		go(6'h13, 6'h1f, base + 19'h2, 0);
		$display("test writes done");
		for (i = 0; i < 2; i++) begin
			mode = i[0];
			go(6'h13, 6'h3f, base + ADDR_W'($urandom % 4), 0);
			repeat (6) go($urandom % 2 ? 6'h16 : 6'h17, 6'h3f, base, 0);
		end
		$display("test bursts done");
		for (i = 0; i < 4; i++) go(6'h15, {2'h2, 4'($urandom)}, base + ADDR_W'(i), 0);
		go(6'h13, 6'h3f, base, 0);
		repeat (3) go(6'h16, 6'h3f, base, 0);
		$display("test lanes done");
		for (i = 0; i < 8; i++) begin
			go({i[2:0], 3'h5}, 6'h1f, base, 0);
			go({i[2:0], 3'h3}, 6'h3f, base, 0);
		end
		go(6'h13, 6'h3f, base, 0);
		oen = 1'b1;
		go(6'h13, 6'h3f, base, 0);
		oen = 1'b0;
		$display("test selects done");
		go(6'h33, 6'h3f, base, 0);
		repeat (3) go(6'h33, 6'h3f, base, 1);
		go(6'h16, 6'h3f, base, 0);
		go(6'h13, 6'h3f, base, 0);
		$display("test sleep done");
		repeat (3) @(posedge clock);
		results();
	end
endmodule : tb_sync_burst_sram_port
